// *** src/pdc_pkg.sv ***
// shared constants, register map and state types of the peripheral dma channel
package pdc_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses on apb)
   // ----------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_INT_STATUS = 8'h08;
   localparam logic [7:0] OFF_INT_MASK = 8'h0C;
   localparam logic [7:0] OFF_FETCH_ADDR = 8'h10;
   localparam logic [7:0] OFF_FETCH_MAX = 8'h14;
   localparam logic [7:0] OFF_FETCH_COUNT = 8'h18;
   localparam logic [7:0] OFF_STORE_ADDR = 8'h1C;
   localparam logic [7:0] OFF_STORE_MAX = 8'h20;
   localparam logic [7:0] OFF_STORE_COUNT = 8'h24;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_FETCH_GO = 0;
   localparam int CTRL_STORE_GO = 1;
   localparam int CTRL_FETCH_LIST = 2;
   localparam int CTRL_STORE_LIST = 3;
   localparam int CTRL_DROP = 4;
   localparam int CTRL_STORE_STOP = 5;
   localparam int INT_W = 5;
   localparam int INT_FETCH_DONE = 0;
   localparam int INT_STORE_DONE = 1;
   localparam int INT_BUS_ERR = 2;
   localparam int INT_ADDR_ERR = 3;
   localparam int INT_DROP = 4;
   // ----------------------------------------------------------------
   // bus encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [31:0] PTR_RST = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {F_IDLE = 3'h1, F_READ = 3'h2, F_OUT = 3'h4} pdc_fetch_state_t;
   typedef enum logic [2:0] {S_IDLE = 3'h1, S_WAIT = 3'h2, S_WRITE = 3'h4} pdc_store_state_t;
   typedef enum logic [2:0] {OWN_NONE = 3'h1, OWN_FETCH = 3'h2, OWN_STORE = 3'h4} pdc_owner_t;
   typedef enum logic [2:0] {P_IDLE = 3'h1, P_ADDR = 3'h2, P_DATA = 3'h4} pdc_port_state_t;
   // picks one byte lane out of a bus word
   function automatic logic [7:0] pdc_lane_byte(input logic [31:0] w, input logic [1:0] l);
      return w[l*8 +: 8];
   endfunction : pdc_lane_byte
endpackage : pdc_pkg

// *** src/pdc_bus_if.sv ***
// byte request path between the channel engine and its ahb port
`timescale 1ns/100ps
interface pdc_bus_if;
   logic req;
   logic write;
   logic [31:0] addr;
   logic [7:0] wdata;
   logic done;
   logic err;
   logic [7:0] rdata;
   modport engine(output req, write, addr, wdata, input done, err, rdata);
   modport port(input req, write, addr, wdata, output done, err, rdata);
endinterface : pdc_bus_if

// *** src/pdc_ahb_port.sv ***
// single-byte ahb-lite master port used by the channel engine
`timescale 1ns/100ps
module pdc_ahb_port (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // engine side
   pdc_bus_if.port bus,
   // ahb-lite master
   output logic [1:0] htrans,
   output logic [31:0] haddr,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hresp
);
   import pdc_pkg::*;

   typedef struct packed {
      pdc_port_state_t st;
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic done;
      logic err;
      logic [7:0] rdata;
   } pdc_port_t;

   pdc_port_t s;
   pdc_port_t n;

   // ----------------------------------------------------------------
   // address phase, data phase, answer
   // ----------------------------------------------------------------
   // next state of the port
   always_comb begin
      n = s;
      n.done = 1'b0;
      case (s.st)
         P_IDLE: begin
            // guard on done: the request is still high in the answer cycle
            if (bus.req && !s.done) begin
               n.st = P_ADDR;
               n.htrans = HTRANS_NONSEQ;
               n.haddr = bus.addr;
               n.hwrite = bus.write;
               n.hsize = HSIZE_BYTE;
               n.hwdata = {4{bus.wdata}};
            end
         end
         P_ADDR: begin
            if (hready) begin
               n.st = P_DATA;
               n.htrans = HTRANS_IDLE;
            end
         end
         P_DATA: begin
            if (hready) begin
               n.st = P_IDLE;
               n.done = 1'b1;
               n.err = hresp;
               n.rdata = pdc_lane_byte(hrdata, s.haddr[1:0]);
            end
         end
         default: begin
            n.st = P_IDLE;
            n.htrans = HTRANS_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.st <= P_IDLE;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state
   assign htrans = s.htrans;
   assign haddr = s.haddr;
   assign hwrite = s.hwrite;
   assign hsize = s.hsize;
   assign hwdata = s.hwdata;
   assign bus.done = s.done;
   assign bus.err = s.err;
   assign bus.rdata = s.rdata;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   addr_hold_a: assert property (s.st == P_ADDR && !hready |=> $stable(haddr) && htrans == HTRANS_NONSEQ) else $error("address phase not held");
   lane_read_a: assert property (s.st == P_DATA && hready |=> bus.done && bus.rdata == pdc_lane_byte($past(hrdata), haddr[1:0])) else $error("wrong read lane");
   lane_write_a: assert property (htrans == HTRANS_NONSEQ |-> hwdata == {4{hwdata[7:0]}} && hsize == HSIZE_BYTE) else $error("write lanes not replicated");
endmodule : pdc_ahb_port

// *** src/pdc_channel.sv ***
// peripheral dma channel: fetch and store engines, apb registers, interrupt
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module pdc_channel #(
   parameter int CNT_W = 16,
   parameter logic [31:0] RAM_BASE = 32'h2000_0000,
   parameter logic [31:0] RAM_SIZE = 32'h0001_0000,
   parameter bit HAS_LIST = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pdc_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // ahb-lite master
   output logic [1:0] htrans,
   output logic [31:0] haddr,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // fetched bytes towards the peripheral
   output logic fetch_valid,
   output logic [7:0] fetch_data,
   input wire logic fetch_ready,
   // bytes from the peripheral to store
   input wire logic store_valid,
   input wire logic [7:0] store_data,
   input wire logic store_last,
   output logic store_ready,
   // interrupt
   output logic irq
);
   import pdc_pkg::*;

   typedef struct packed {
      pdc_fetch_state_t fst;
      pdc_store_state_t sst;
      pdc_owner_t owner;
      logic fetch_list;
      logic store_list;
      logic drop_mode;
      logic [31:0] fetch_base;
      logic [31:0] fetch_cur;
      logic [31:0] store_base;
      logic [31:0] store_cur;
      logic [CNT_W-1:0] fetch_max;
      logic [CNT_W-1:0] fetch_cnt;
      logic [CNT_W-1:0] store_max;
      logic [CNT_W-1:0] store_cnt;
      logic [INT_W-1:0] int_status;
      logic [INT_W-1:0] int_mask;
      logic irq;
      logic [7:0] fetch_data;
      logic fetch_valid;
      logic [7:0] store_data;
      logic store_last;
      logic store_ready;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } pdc_state_t;

   pdc_state_t s;
   pdc_state_t n;
   pdc_bus_if bus ();
   logic wr;
   logic fetch_go;
   logic store_go;
   logic store_stop;
   logic [INT_W-1:0] set;
   logic [INT_W-1:0] clr;

   // true when the whole byte address lies inside the ram window
   function automatic logic in_ram(input logic [31:0] a);
      return (a >= RAM_BASE) && ((a - RAM_BASE) < RAM_SIZE);
   endfunction : in_ram

   // ----------------------------------------------------------------
   // ahb port and its request
   // ----------------------------------------------------------------
   pdc_ahb_port pdc_ahb_port_inst (
      .clk(clk),
      .resetn(resetn),
      .bus(bus.port),
      .htrans(htrans),
      .haddr(haddr),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hresp(hresp)
   );

   // request of whichever channel owns the port
   assign bus.req = (s.owner == OWN_FETCH && s.fst == F_READ) ||
                    (s.owner == OWN_STORE && s.sst == S_WRITE);
   assign bus.write = (s.owner == OWN_STORE);
   assign bus.addr = (s.owner == OWN_STORE) ? s.store_cur : s.fetch_cur;
   assign bus.wdata = s.store_data;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      set = '0;
      clr = '0;
      fetch_go = 1'b0;
      store_go = 1'b0;
      store_stop = 1'b0;
      wr = psel && penable && pwrite && s.pready;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.prdata = RD_ZERO;

      // register writes take effect at the edge that completes the transfer
      if (wr) begin
         case (paddr)
            OFF_CTRL: begin
               fetch_go = pwdata[CTRL_FETCH_GO];
               store_go = pwdata[CTRL_STORE_GO];
               store_stop = pwdata[CTRL_STORE_STOP];
               n.drop_mode = pwdata[CTRL_DROP];
               // list bits only where built in
               n.fetch_list = HAS_LIST && pwdata[CTRL_FETCH_LIST];
               n.store_list = HAS_LIST && pwdata[CTRL_STORE_LIST];
            end
            OFF_INT_STATUS: clr = pwdata[INT_W-1:0];
            OFF_INT_MASK: n.int_mask = pwdata[INT_W-1:0];
            // pointers and limits are frozen while a channel runs
            OFF_FETCH_ADDR: if (s.fst == F_IDLE) n.fetch_base = pwdata;
            OFF_FETCH_MAX: if (s.fst == F_IDLE) n.fetch_max = pwdata[CNT_W-1:0];
            OFF_STORE_ADDR: if (s.sst == S_IDLE) n.store_base = pwdata;
            OFF_STORE_MAX: if (s.sst == S_IDLE) n.store_max = pwdata[CNT_W-1:0];
            default: ;
         endcase
      end

      // read answer, one cycle into the access phase
      if (psel && penable && !s.pready) begin
         n.pready = 1'b1;
         case (paddr)
            OFF_CTRL: n.prdata = 32'(s.drop_mode) << CTRL_DROP |
                                 32'(s.fetch_list) << CTRL_FETCH_LIST |
                                 32'(s.store_list) << CTRL_STORE_LIST;
            OFF_STATUS: n.prdata = {30'h0000_0000, s.sst != S_IDLE, s.fst != F_IDLE};
            OFF_INT_STATUS: n.prdata = 32'(s.int_status);
            OFF_INT_MASK: n.prdata = 32'(s.int_mask);
            OFF_FETCH_ADDR: n.prdata = s.fetch_base;
            OFF_FETCH_MAX: n.prdata = 32'(s.fetch_max);
            OFF_FETCH_COUNT: n.prdata = 32'(s.fetch_cnt);
            OFF_STORE_ADDR: n.prdata = s.store_base;
            OFF_STORE_MAX: n.prdata = 32'(s.store_max);
            OFF_STORE_COUNT: n.prdata = 32'(s.store_cnt);
            default: n.pslverr = 1'b1;
         endcase
      end

      case (s.fst)
         F_IDLE: begin
            if (fetch_go) begin
               n.fetch_cur = s.fetch_base;
               n.fetch_cnt = '0;
               if (s.fetch_max == '0) begin
                  set[INT_FETCH_DONE] = 1'b1;
               end else begin
                  n.fst = F_READ;
               end
            end
         end
         F_READ: begin
            if (!in_ram(s.fetch_cur)) begin
               set[INT_ADDR_ERR] = 1'b1;
               n.fst = F_IDLE;
            end else if (s.owner == OWN_FETCH && bus.done) begin
               if (bus.err) begin
                  set[INT_BUS_ERR] = 1'b1;
                  n.fst = F_IDLE;
               end else begin
                  n.fetch_data = bus.rdata;
                  n.fetch_valid = 1'b1;
                  n.fst = F_OUT;
               end
            end
         end
         F_OUT: begin
            if (fetch_ready) begin
               n.fetch_valid = 1'b0;
               n.fetch_cnt = s.fetch_cnt + 1'b1;
               n.fetch_cur = s.fetch_cur + 32'h0000_0001;
               if (n.fetch_cnt == s.fetch_max) begin
                  set[INT_FETCH_DONE] = 1'b1;
                  n.fst = F_IDLE;
                  if (s.fetch_list) n.fetch_base = s.fetch_base + 32'(s.fetch_max);
               end else begin
                  n.fst = F_READ;
               end
            end
         end
         default: n.fst = F_IDLE;
      endcase

      case (s.sst)
         S_IDLE: begin
            if (store_go) begin
               n.store_cur = s.store_base;
               n.store_cnt = '0;
               if (s.store_max == '0) begin
                  set[INT_STORE_DONE] = 1'b1;
               end else begin
                  n.sst = S_WAIT;
               end
            end
         end
         S_WAIT: begin
            if (store_stop) begin
               set[INT_STORE_DONE] = 1'b1;
               n.sst = S_IDLE;
            end else if (store_valid && s.store_ready) begin
               n.store_data = store_data;
               n.store_last = store_last;
               n.sst = S_WRITE;
            end
         end
         S_WRITE: begin
            // a byte offered while the port is busy is lost in drop mode
            if (s.drop_mode && store_valid && s.store_ready) set[INT_DROP] = 1'b1;
            if (!in_ram(s.store_cur)) begin
               set[INT_ADDR_ERR] = 1'b1;
               n.sst = S_IDLE;
            end else if (s.owner == OWN_STORE && bus.done) begin
               if (bus.err) begin
                  set[INT_BUS_ERR] = 1'b1;
                  n.sst = S_IDLE;
               end else begin
                  n.store_cnt = s.store_cnt + 1'b1;
                  n.store_cur = s.store_cur + 32'h0000_0001;
                  // end at max count or early on last byte
                  if (n.store_cnt == s.store_max || s.store_last) begin
                     set[INT_STORE_DONE] = 1'b1;
                     n.sst = S_IDLE;
                     // next item directly after this one
                     if (s.store_list) n.store_base = s.store_base + 32'(s.store_max);
                  end else begin
                     n.sst = S_WAIT;
                  end
               end
            end
         end
         default: n.sst = S_IDLE;
      endcase

      // ready is held low while a write waits for the bus, unless dropping
      n.store_ready = (n.sst == S_WAIT) || (n.drop_mode && n.sst == S_WRITE);

      // fetch has priority; the grant holds until the transfer ends
      case (s.owner)
         OWN_NONE: begin
            if (s.fst == F_READ && in_ram(s.fetch_cur)) begin
               n.owner = OWN_FETCH;
            end else if (s.sst == S_WRITE && in_ram(s.store_cur)) begin
               n.owner = OWN_STORE;
            end
         end
         OWN_FETCH, OWN_STORE: if (bus.done) n.owner = OWN_NONE;
         default: n.owner = OWN_NONE;
      endcase

      // sticky events, the set wins over a clear in the same cycle
      n.int_status = (s.int_status & ~clr) | set;
      n.irq = |(n.int_status & n.int_mask);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // pointers reset to a value software must replace
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.fst <= F_IDLE;
         s.sst <= S_IDLE;
         s.owner <= OWN_NONE;
         s.fetch_base <= PTR_RST;
         s.store_base <= PTR_RST;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign fetch_valid = s.fetch_valid;
   assign fetch_data = s.fetch_data;
   assign store_ready = s.store_ready;
   assign irq = s.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   ram_only_a: assert property (htrans == HTRANS_NONSEQ |-> in_ram(haddr)) else $error("access outside ram");
   fetch_exact_a: assert property (s.fst == F_OUT && fetch_ready && s.fetch_cnt + 1'b1 == s.fetch_max |=> s.fst == F_IDLE && s.int_status[INT_FETCH_DONE] && s.fetch_cnt == $past(s.fetch_max)) else $error("fetch count not exact");
   store_max_a: assert property (s.sst != S_IDLE |-> s.store_cnt < s.store_max) else $error("store past max count");
   count_hold_a: assert property (s.fst == F_IDLE && !fetch_go |=> $stable(s.fetch_cnt)) else $error("fetch count moved while idle");
   bus_err_a: assert property (s.owner == OWN_FETCH && bus.done && bus.err |=> s.fst == F_IDLE && s.int_status[INT_BUS_ERR]) else $error("bus error not reported");
   stall_a: assert property (!s.drop_mode && s.sst == S_WRITE |-> !store_ready) else $error("store not stalled");
   drop_flag_a: assert property (s.drop_mode && s.sst == S_WRITE && store_valid && store_ready |=> s.int_status[INT_DROP]) else $error("drop not flagged");
   list_off_a: assert property (!HAS_LIST |-> !s.fetch_list && !s.store_list) else $error("list mode without list setting");
   grant_first_a: assert property (s.owner == OWN_NONE && s.fst == F_READ && in_ram(s.fetch_cur) |=> s.owner == OWN_FETCH ##1 bus.req) else $error("fetch not granted first");
   list_step_a: assert property (s.fetch_list && s.fst == F_OUT && fetch_ready && s.fetch_cnt + 1'b1 == s.fetch_max |=> s.fetch_base == $past(s.fetch_base) + 32'($past(s.fetch_max))) else $error("list item not advanced");
   fetch_done_c: cover property (s.fst == F_OUT ##1 s.fst == F_IDLE && s.int_status[INT_FETCH_DONE]);
   store_early_c: cover property (s.sst == S_WRITE && s.store_last && bus.done && s.store_cnt + 1'b1 < s.store_max);
   list_c: cover property (s.store_list && s.sst == S_WRITE ##1 s.sst == S_IDLE);
   drop_c: cover property (s.drop_mode && s.sst == S_WRITE && store_valid && store_ready);
endmodule : pdc_channel

// *** src/dummy_never_used_placeholder_removed.sv ***
// intentionally minimal: no logic in this file
`timescale 1ns/100ps

// *** bench/pdc_ram_model.sv ***
// ahb ram slave model with wait states and error reply
`timescale 1ns/100ps
module pdc_ram_model (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // ahb request
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   // test controls
   input wire logic [1:0] waits,
   input wire logic err_on,
   // ahb reply
   output logic hready,
   output logic [31:0] hrdata,
   output logic hresp
);
   logic [7:0] mem [0:63];
   logic act;
   logic wr;
   logic [31:0] a;
   logic [1:0] cnt;
   // stall the master for waits cycles
   assign hready = !act || cnt == waits;
   assign hresp = act && hready && err_on;
   // own lane carries the byte, other lanes a changing filler
   always_comb begin
      hrdata = {8{cnt, ~cnt}};
      if (act)
         hrdata[a[1:0]*8 +: 8] = mem[a[5:0]];
   end
   // data phase tracking and byte store
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         act <= 1'b0;
         cnt <= 2'h0;
      end else if (hready) begin
         if (act && wr && !err_on)
            mem[a[5:0]] <= hwdata[a[1:0]*8 +: 8];
         act <= htrans == 2'h2;
         wr <= hwrite;
         a <= haddr;
         cnt <= 2'h0;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule : pdc_ram_model

// *** bench/pdc_channel_test.sv ***
// self-checking bench of the peripheral dma channel
`timescale 1ns/100ps
module pdc_channel_test;
   import pdc_pkg::*;
   localparam logic [31:0] BASE = 32'h2000_0000;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, fetch_ready = 0, err_on = 0;
   logic store_valid = 0, store_last = 0, se, pready, pslverr, hready, hresp, hwrite;
   logic fetch_valid, store_ready, irq;
   logic [1:0] waits = 0, htrans;
   logic [2:0] hsize;
   logic [7:0] paddr = 0, store_data = 0, fetch_data;
   logic [31:0] pwdata = 0, rd, prdata, haddr, hwdata, hrdata;
   int num_errors = 0, tests_run = 0, cyc = 0;
   always #25 clk = ~clk;
   pdc_channel pdc_channel_inst (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .htrans, .haddr, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hresp, .fetch_valid, .fetch_data, .fetch_ready, .store_valid, .store_data, .store_last,
      .store_ready, .irq);
   pdc_ram_model pdc_ram_model_inst (.clk, .resetn, .htrans, .haddr, .hwrite, .hwdata, .waits,
      .err_on, .hready, .hrdata, .hresp);
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // wait for the answer; only the cycle limit ends a hang
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask : apb
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(0, a, 0);
      chk(what, rd, exp);
   endtask : rdchk
   task automatic wait_idle();
      do apb(0, OFF_STATUS, 0); while (rd[1:0] !== 2'b00);
   endtask : wait_idle
   task automatic take(input int n, input int off);
      fetch_ready <= 1;
      for (int i = 0; i < n; i++) begin
         do @(posedge clk); while (fetch_valid !== 1'b1);
         chk("fetch_data", {24'h0, fetch_data}, 32'(off + i + 48));
      end
      fetch_ready <= 0;
   endtask : take
   task automatic send(input logic [7:0] d, input logic l);
      store_valid <= 1;
      store_data <= d;
      store_last <= l;
      do @(posedge clk); while (store_ready !== 1'b1);
      store_valid <= 0;
      @(posedge clk);
   endtask : send
   task automatic t_regs();
      rdchk("fetch_addr", OFF_FETCH_ADDR, PTR_RST);
      apb(0, 8'h40, 0);
      chk("slverr", {31'h0, se}, 1);
      apb(1, OFF_INT_MASK, 32'h0000_001F);
      rdchk("int_mask", OFF_INT_MASK, 32'h0000_001F);
   endtask : t_regs
   task automatic t_fetch();
      apb(1, OFF_FETCH_ADDR, BASE + 1);
      apb(1, OFF_FETCH_MAX, 5);
      apb(1, OFF_CTRL, 1);
      take(5, 1);
      wait_idle();
      rdchk("fetch_count", OFF_FETCH_COUNT, 5);
      apb(0, OFF_INT_STATUS, 0);
      chk("int_status", rd, 32'h0000_0001);
      chk("irq", {31'h0, irq}, 1);
      apb(1, OFF_INT_STATUS, 32'h0000_001F);
      rdchk("int_clear", OFF_INT_STATUS, 0);
      chk("irq_low", {31'h0, irq}, 0);
   endtask : t_fetch
   task automatic t_store();
      waits <= 2;
      apb(1, OFF_STORE_ADDR, BASE + 5);
      apb(1, OFF_STORE_MAX, 6);
      apb(1, OFF_CTRL, 2);
      send(8'hC1, 0);
      send(8'hC2, 0);
      send(8'hC3, 1);
      wait_idle();
      rdchk("store_count", OFF_STORE_COUNT, 3);
      for (int i = 0; i < 4; i++)
         chk("ram", {24'h0, pdc_ram_model_inst.mem[5 + i]}, i < 3 ? 32'hC1 + i : 32'h38);
      waits <= 0;
   endtask : t_store
   task automatic t_list();
      apb(1, OFF_FETCH_ADDR, BASE + 16);
      apb(1, OFF_FETCH_MAX, 4);
      for (int j = 0; j < 2; j++) begin
         apb(1, OFF_CTRL, 5);
         take(4, 16 + 4 * j);
         wait_idle();
         rdchk("item_count", OFF_FETCH_COUNT, 4);
      end
      rdchk("list_base", OFF_FETCH_ADDR, BASE + 24);
   endtask : t_list
   // drop mode: a byte offered during a write is lost, then stop ends early
   task automatic t_drop();
      apb(1, OFF_INT_STATUS, 32'h0000_001F);
      apb(1, OFF_STORE_ADDR, BASE + 32);
      apb(1, OFF_STORE_MAX, 4);
      apb(1, OFF_CTRL, 32'h0000_0012);
      send(8'hD1, 0);
      send(8'hD2, 0);
      repeat (12) @(posedge clk);
      apb(1, OFF_CTRL, 32'h0000_0020);
      rdchk("drop_status", OFF_INT_STATUS, 32'h0000_0012);
      rdchk("stop_count", OFF_STORE_COUNT, 1);
      chk("kept_ram", {24'h0, pdc_ram_model_inst.mem[32]}, 32'hD1);
      chk("drop_ram", {24'h0, pdc_ram_model_inst.mem[33]}, 32'h51);
   endtask : t_drop
   task automatic t_err();
      apb(1, OFF_INT_STATUS, 32'h0000_001F);
      apb(1, OFF_INT_MASK, 0);
      apb(1, OFF_FETCH_ADDR, 32'h0000_0100);
      apb(1, OFF_FETCH_MAX, 2);
      apb(1, OFF_CTRL, 1);
      wait_idle();
      err_on <= 1;
      apb(1, OFF_STORE_ADDR, BASE);
      apb(1, OFF_STORE_MAX, 1);
      apb(1, OFF_CTRL, 2);
      send(8'h77, 1);
      wait_idle();
      apb(0, OFF_INT_STATUS, 0);
      chk("errors", {30'h0, rd[3:2]}, 3);
      chk("masked_irq", {31'h0, irq}, 0);
      rdchk("err_count", OFF_STORE_COUNT, 0);
      err_on <= 0;
   endtask : t_err
   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // watch every address phase, plus hang limit
   always @(posedge clk) begin
      cyc++;
      if (htrans === HTRANS_NONSEQ)
         chk("haddr", {16'h0, haddr[31:16]}, 32'h2000);
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      for (int i = 0; i < 64; i++)
         pdc_ram_model_inst.mem[i] = 8'(i + 48);
      repeat (3) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      t_regs();
      t_fetch();
      t_store();
      t_list();
      t_drop();
      t_err();
      finish_test();
   end
endmodule : pdc_channel_test
